//--- core/ufa_frame_aggregator.v
// Purpose: serial receive, frame grouping and mode select toward the network side
// Assumes: rx pin asynchronous to pclk; 8N1 serial; net side handshakes on pclk
// Notes: bytes arriving while a frame drains are dropped and flagged
// Functional notes
// - with gap framing on, close the frame once the idle gap exceeds the setting.
// - without a gap, close and forward the frame when 1000 bytes are held.
// - gap setting is fast 200ms or normal 250ms; normal after reset.
// - with auto-frame on, forward once byte count reaches the trigger length.
// - trigger time expiring first forwards held bytes regardless of length.
// - trigger time starts at the first byte of a new frame.
// - throughput, command and gpio modes are exclusive; throughput passes bytes unchanged.
// - command mode stops forwarding and hands bytes to the command side.
// - throughput mode requests network association automatically after power-up.
`timescale 1ns/1ns
`include "ufa_consts.vh"

module ufa_frame_aggregator #(
	parameter TICK_CYCLES = `UFA_CLK_HZ / 1000 * `UFA_TICK_MS
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// serial receive pin
	input wire rx_pin,
	// network frame stream
	output reg [7:0] net_data,
	output reg net_valid,
	output reg net_last,
	input wire net_ready,
	// command byte stream
	output reg [7:0] cmd_byte,
	output reg cmd_valid,
	// network association
	input wire net_link_up,
	output wire net_join_req
);

	localparam ST_COLLECT = 2'h0;
	localparam ST_FETCH = 2'h1;
	localparam ST_LOAD = 2'h2;
	localparam ST_SEND = 2'h3;
	localparam RX_IDLE = 2'h0;
	localparam RX_START = 2'h1;
	localparam RX_DATA = 2'h2;
	localparam RX_STOP = 2'h3;

	reg [5:0] ctrl_q;
	reg [9:0] len_q;
	reg [15:0] time_q;
	reg [15:0] baud_q;
	reg ovr_q;
	reg ferr_q;
	reg rx_s1_q, rx_s2_q;
	reg [1:0] rx_st_q;
	reg [15:0] rx_cnt_q;
	reg [2:0] rx_bit_q;
	reg [7:0] rx_sh_q;
	reg rx_done_q;
	reg [31:0] tick_cnt_q;
	reg tick_q;
	reg [1:0] st_q;
	reg [9:0] cnt_q;
	reg [9:0] rd_addr_q;
	reg [15:0] gap_ms_q;
	reg [15:0] trig_ms_q;
	wire [7:0] mem_rd;
	wire [1:0] mode;
	wire [15:0] gap_lim;
	wire byte_thru;
	wire close;
	wire wr_acc;
	wire addr_ok;
	reg [31:0] rd_mux;

	assign mode = ctrl_q[`UFA_CTRL_MODE_HI:`UFA_CTRL_MODE_LO];
	assign pready = 1'b1;
	assign addr_ok = (paddr == `UFA_ADDR_CTRL) || (paddr == `UFA_ADDR_LEN) || (paddr == `UFA_ADDR_TIME) ||
		(paddr == `UFA_ADDR_BAUD) || (paddr == `UFA_ADDR_STAT);
	assign pslverr = psel && penable && !addr_ok;
	assign wr_acc = psel && penable && pwrite && addr_ok;

	// read mux
	always @* begin
		rd_mux = 32'h0000_0000;
		if (paddr == `UFA_ADDR_CTRL) begin
			rd_mux[5:0] = ctrl_q;
		end else if (paddr == `UFA_ADDR_LEN) begin
			rd_mux[9:0] = len_q;
		end else if (paddr == `UFA_ADDR_TIME) begin
			rd_mux[15:0] = time_q;
		end else if (paddr == `UFA_ADDR_BAUD) begin
			rd_mux[15:0] = baud_q;
		end else if (paddr == `UFA_ADDR_STAT) begin
			rd_mux[`UFA_STAT_CNT_HI:0] = cnt_q;
			rd_mux[`UFA_STAT_BUSY] = (st_q != ST_COLLECT);
			rd_mux[`UFA_STAT_OVR] = ovr_q;
			rd_mux[`UFA_STAT_FERR] = ferr_q;
			rd_mux[`UFA_STAT_MODE_LO+1:`UFA_STAT_MODE_LO] = mode;
		end
	end

	// read data captured in the setup phase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rd_mux;
		end
	end

	// configuration registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `UFA_CTRL_RST;
			len_q <= `UFA_LEN_RST;
			time_q <= `UFA_TIME_RST;
			baud_q <= `UFA_BAUD_RST;
		end else if (wr_acc) begin
			if (paddr == `UFA_ADDR_CTRL) begin
				ctrl_q <= pwdata[5:0];
			end else if (paddr == `UFA_ADDR_LEN) begin
				len_q <= pwdata[9:0];
			end else if (paddr == `UFA_ADDR_TIME) begin
				time_q <= pwdata[15:0];
			end else if (paddr == `UFA_ADDR_BAUD) begin
				baud_q <= pwdata[15:0];
			end
		end
	end

	// rx pin synchroniser
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
		end else begin
			rx_s1_q <= rx_pin;
			rx_s2_q <= rx_s1_q;
		end
	end

	// 8N1 receiver, baud_q cycles per bit, lsb first
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_st_q <= RX_IDLE;
			rx_cnt_q <= 16'h0000;
			rx_bit_q <= 3'h0;
			rx_sh_q <= 8'h00;
			rx_done_q <= 1'b0;
		end else begin
			rx_done_q <= 1'b0;
			if (rx_cnt_q != 16'h0000) begin
				rx_cnt_q <= rx_cnt_q - 16'h0001;
			end
			case (rx_st_q)
			RX_IDLE: begin
				if (!rx_s2_q) begin
					rx_st_q <= RX_START;
					rx_cnt_q <= {1'b0, baud_q[15:1]};
				end
			end
			RX_START: begin
				if (rx_cnt_q == 16'h0000) begin
					rx_st_q <= rx_s2_q ? RX_IDLE : RX_DATA;
					rx_cnt_q <= baud_q - 16'h0001; // count to zero inclusive, so reload one less
					rx_bit_q <= 3'h0;
				end
			end
			RX_DATA: begin
				if (rx_cnt_q == 16'h0000) begin
					rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]};
					rx_cnt_q <= baud_q - 16'h0001; // keeps the bit period at baud_q cycles
					rx_bit_q <= rx_bit_q + 3'h1;
					if (rx_bit_q == 3'h7) begin
						rx_st_q <= RX_STOP;
					end
				end
			end
			default: begin
				if (rx_cnt_q == 16'h0000) begin
					rx_st_q <= RX_IDLE;
					rx_done_q <= rx_s2_q;
				end
			end
			endcase
		end
	end

	// millisecond tick
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_q <= 32'h0000_0000;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (tick_cnt_q == TICK_CYCLES - 1);
			tick_cnt_q <= (tick_cnt_q == TICK_CYCLES - 1) ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
		end
	end

	// mode routing: only throughput feeds frames
	assign byte_thru = rx_done_q && (mode == `UFA_MODE_THRU);
	assign gap_lim = ctrl_q[`UFA_CTRL_GAP_FAST] ? `UFA_GAP_FAST_MS : `UFA_GAP_NORMAL_MS;
	assign net_join_req = (mode == `UFA_MODE_THRU) && !net_link_up;

	// frame close conditions, only with bytes held
	assign close = (st_q == ST_COLLECT) && (cnt_q != 10'h000) && (
		(cnt_q >= `UFA_MAX_FRAME) ||
		(ctrl_q[`UFA_CTRL_GAP_EN] && gap_ms_q > gap_lim) ||
		(ctrl_q[`UFA_CTRL_AF_EN] && len_q != 10'h000 && cnt_q >= len_q) ||
		(ctrl_q[`UFA_CTRL_AF_EN] && time_q != 16'h0000 && trig_ms_q >= time_q));

	// command bytes out
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_byte <= 8'h00;
			cmd_valid <= 1'b0;
		end else begin
			cmd_valid <= rx_done_q && (mode == `UFA_MODE_CMD);
			if (rx_done_q) begin
				cmd_byte <= rx_sh_q;
			end
		end
	end

	// status flags, set wins over clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovr_q <= 1'b0;
			ferr_q <= 1'b0;
		end else begin
			if (byte_thru && st_q != ST_COLLECT) begin
				ovr_q <= 1'b1;
			end else if (wr_acc && paddr == `UFA_ADDR_STAT && pwdata[`UFA_STAT_OVR]) begin
				ovr_q <= 1'b0;
			end
			if (rx_st_q == RX_STOP && rx_cnt_q == 16'h0000 && !rx_s2_q) begin
				ferr_q <= 1'b1;
			end else if (wr_acc && paddr == `UFA_ADDR_STAT && pwdata[`UFA_STAT_FERR]) begin
				ferr_q <= 1'b0;
			end
		end
	end

	// frame collect and drain
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= ST_COLLECT;
			cnt_q <= 10'h000;
			rd_addr_q <= 10'h000;
			gap_ms_q <= 16'h0000;
			trig_ms_q <= 16'h0000;
			net_data <= 8'h00;
			net_valid <= 1'b0;
			net_last <= 1'b0;
		end else begin
			case (st_q)
			ST_COLLECT: begin
				if (close) begin
					st_q <= ST_FETCH;
					rd_addr_q <= 10'h000;
				end else if (byte_thru) begin
					cnt_q <= cnt_q + 10'h001;
					gap_ms_q <= 16'h0000;
					if (cnt_q == 10'h000) begin
						trig_ms_q <= 16'h0000;
					end else if (tick_q && trig_ms_q != 16'hFFFF) begin
						trig_ms_q <= trig_ms_q + 16'h0001;
					end
				end else if (tick_q && cnt_q != 10'h000) begin
					if (gap_ms_q != 16'hFFFF) begin
						gap_ms_q <= gap_ms_q + 16'h0001;
					end
					if (trig_ms_q != 16'hFFFF) begin
						trig_ms_q <= trig_ms_q + 16'h0001;
					end
				end
			end
			ST_FETCH: begin
				st_q <= ST_LOAD;
			end
			ST_LOAD: begin
				net_data <= mem_rd;
				net_valid <= 1'b1;
				net_last <= (rd_addr_q == cnt_q - 10'h001);
				st_q <= ST_SEND;
			end
			default: begin
				if (net_ready) begin
					net_valid <= 1'b0;
					net_last <= 1'b0;
					if (net_last) begin
						st_q <= ST_COLLECT;
						cnt_q <= 10'h000;
						gap_ms_q <= 16'h0000;
						trig_ms_q <= 16'h0000;
					end else begin
						rd_addr_q <= rd_addr_q + 10'h001;
						st_q <= ST_FETCH;
					end
				end
			end
			endcase
		end
	end

	// frame byte store
	ufa_frame_mem u_mem (
		.pclk(pclk),
		.wr_en(byte_thru && st_q == ST_COLLECT && !close),
		.wr_addr(cnt_q),
		.wr_data(rx_sh_q),
		.rd_addr(rd_addr_q),
		.rd_data(mem_rd)
	);

endmodule // ufa_frame_aggregator

//--- core/ufa_consts.vh
// Purpose: shared constants of the serial frame aggregator
// Assumes: 25 MHz pclk, 32-bit APB register bus
// Notes: definitions only
`ifndef UFA_CONSTS_VH
`define UFA_CONSTS_VH

// register byte offsets
`define UFA_ADDR_CTRL 8'h00
`define UFA_ADDR_LEN 8'h04
`define UFA_ADDR_TIME 8'h08
`define UFA_ADDR_BAUD 8'h0C
`define UFA_ADDR_STAT 8'h10

// control field positions
`define UFA_CTRL_GAP_EN 0
`define UFA_CTRL_GAP_FAST 1
`define UFA_CTRL_AF_EN 2
`define UFA_CTRL_MODE_LO 4
`define UFA_CTRL_MODE_HI 5

// status field positions
`define UFA_STAT_CNT_HI 9
`define UFA_STAT_BUSY 12
`define UFA_STAT_OVR 13
`define UFA_STAT_FERR 14
`define UFA_STAT_MODE_LO 16

// operating modes
`define UFA_MODE_THRU 2'h0
`define UFA_MODE_CMD 2'h1
`define UFA_MODE_GPIO 2'h2

// reset values
`define UFA_CTRL_RST 6'h01
`define UFA_LEN_RST 10'h100
`define UFA_TIME_RST 16'h0064
`define UFA_BAUD_RST 16'h00D9

// timing: gap thresholds and frame ceiling
`define UFA_GAP_NORMAL_MS 16'd250
`define UFA_GAP_FAST_MS 16'd200
`define UFA_MAX_FRAME 10'd1000
`define UFA_CLK_HZ 25000000
`define UFA_TICK_MS 1
`define UFA_HOST_GAP_FAST_MS 10
`define UFA_HOST_GAP_NORMAL_MS 50

`endif

//--- core/ufa_frame_mem.v
// Purpose: frame byte store with registered read data
// Assumes: single pclk, one write and one read port
// Notes: no reset on the array
`timescale 1ns/1ns

module ufa_frame_mem (
	// clock
	input wire pclk,
	// write port
	input wire wr_en,
	input wire [9:0] wr_addr,
	input wire [7:0] wr_data,
	// read port
	input wire [9:0] rd_addr,
	output reg [7:0] rd_data
);

	reg [7:0] mem [0:1023];

	// write and registered read
	always @(posedge pclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end

endmodule // ufa_frame_mem

//--- test/ufa_frame_aggregator_sva.sv
// Purpose: port checker for the frame aggregator
// Assumes: one pclk domain
// Notes: bound to every instance
`timescale 1ns/1ns
module ufa_frame_aggregator_sva (
	// clock, reset, apb
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// streams and link
	input wire [7:0] net_data,
	input wire net_valid,
	input wire net_last,
	input wire net_ready,
	input wire cmd_valid,
	input wire net_link_up,
	input wire net_join_req
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// one frame byte taken by the sink
	sequence s_take;
		net_valid && net_ready;
	endsequence
	// access phase to an unmapped place
	sequence s_bad;
		psel && penable && (paddr > 8'h10 || paddr[1:0] != 2'h0);
	endsequence
	a_zero_wait: assert property (pready) else $error("pready low");
	a_bad_addr: assert property (s_bad |-> pslverr && (pwrite || prdata == 32'h0)) else $error("bad addr");
	a_hold_byte: assert property (net_valid && !net_ready |=> net_valid && $stable(net_data) && $stable(net_last))
		else $error("byte dropped");
	a_byte_space: assert property (s_take |=> !net_valid [*2]) else $error("byte too soon");
	a_frame_idle: assert property (s_take ##0 net_last |=> !net_valid [*3]) else $error("no fresh frame");
	a_cmd_pulse: assert property (cmd_valid |=> !cmd_valid) else $error("cmd pulse long");
	a_cmd_nojoin: assert property (cmd_valid |-> !net_join_req) else $error("join in cmd");
	a_link_up: assert property (net_link_up |-> !net_join_req) else $error("join when up");
endmodule // ufa_frame_aggregator_sva

bind ufa_frame_aggregator ufa_frame_aggregator_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.prdata, .pready, .pslverr, .net_data, .net_valid, .net_last, .net_ready, .cmd_valid, .net_link_up,
	.net_join_req);

//--- test/ufa_host_uart.sv
// Purpose: host serial sender model
// Assumes: 8N1, BIT pclk cycles per bit
// Notes: bytes go out back to back
`timescale 1ns/1ns
module ufa_host_uart #(
	parameter BIT = 4
) (
	// clock and line
	input wire pclk,
	output reg rx_pin
);
	// line idles high
	initial rx_pin = 1'b1;
	// start, data lsb first, stop; no idle gap
	task send(input [7:0] b);
		reg [9:0] sh;
		integer i;
		begin
			sh = {1'b1, b, 1'b0};
			for (i = 0; i < 10; i = i + 1) begin
				@(posedge pclk);
				rx_pin <= sh[i];
				repeat (BIT - 1) @(posedge pclk);
			end
		end
	endtask
endmodule // ufa_host_uart

//--- test/tb_ufa_frame_aggregator.sv
// Purpose: self-checking bench of the frame aggregator
// Assumes: 1 ms tick shortened to 10 cycles
// Notes: sink stalls every other cycle
`timescale 1ns/1ns
module tb_ufa_frame_aggregator;
	reg pclk, presetn, psel, penable, pwrite, net_ready, net_link_up, err;
	reg [7:0] paddr, cmd_got;
	reg [31:0] pwdata, rd;
	reg [7:0] fdat [0:1023];
	wire [31:0] prdata;
	wire pready, pslverr, rx_pin, net_valid, net_last, cmd_valid, net_join_req;
	wire [7:0] net_data, cmd_byte;
	integer err_total = 0, num_checks = 0, frames = 0, cnt = 0, last_len = 0, ncmd = 0, f0, g, i;
	// 25 MHz clock
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	ufa_frame_aggregator #(.TICK_CYCLES(10)) u_ufa_frame_aggregator (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rx_pin(rx_pin), .net_data(net_data), .net_valid(net_valid),
		.net_last(net_last), .net_ready(net_ready), .cmd_byte(cmd_byte), .cmd_valid(cmd_valid),
		.net_link_up(net_link_up), .net_join_req(net_join_req));
	ufa_host_uart #(.BIT(4)) u_ufa_host_uart (.pclk(pclk), .rx_pin(rx_pin));
	// stalling sink and command monitor
	always @(posedge pclk) begin
		net_ready <= ~net_ready;
		if (net_valid && net_ready) begin
			fdat[cnt[9:0]] = net_data;
			cnt = cnt + 1;
			if (net_last) begin
				frames = frames + 1;
				last_len = cnt;
				cnt = 0;
			end
		end
		if (cmd_valid) begin
			ncmd = ncmd + 1;
			cmd_got = cmd_byte;
		end
	end
	task chk(input [31:0] got, input [31:0] exp);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	// setup, access until pready, release
	task apb(input w, input [7:0] a, input [31:0] d);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (pready !== 1'b1) @(posedge pclk);
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task wfr(input integer n, input integer lim);
		integer k;
		begin
			for (k = 0; k < lim && frames < n; k = k + 1) @(posedge pclk);
		end
	endtask
	task t_regs;
		begin
			apb(0, 8'h00, 32'h0);
			chk(rd, 32'h1);
			apb(0, 8'h14, 32'h0);
			chk(err, 1'b1);
			chk(net_join_req, 1'b1);
			net_link_up <= 1'b1;
			repeat (2) @(posedge pclk);
			chk(net_join_req, 1'b0);
			net_link_up <= 1'b0;
			apb(1, 8'h0C, 32'h4);
			$display("t_regs done");
		end
	endtask
	task t_gap(input [31:0] ctl, input integer quiet);
		begin
			apb(1, 8'h00, ctl);
			f0 = frames;
			u_ufa_host_uart.send(8'hA5);
			u_ufa_host_uart.send(8'h3C);
			u_ufa_host_uart.send(8'h81);
			repeat (quiet) @(posedge pclk);
			chk(frames, f0);
			wfr(f0 + 1, 300);
			chk(frames, f0 + 1);
			chk(last_len, 3);
			chk(fdat[0], 8'hA5);
			chk(fdat[2], 8'h81);
			$display("t_gap done");
		end
	endtask
	task t_len;
		begin
			apb(1, 8'h00, 32'h4);
			apb(1, 8'h04, 32'h5);
			apb(1, 8'h08, 32'h32);
			apb(0, 8'h04, 32'h0);
			chk(rd, 32'h5);
			f0 = frames;
			for (i = 0; i < 6; i = i + 1) u_ufa_host_uart.send(i[7:0]);
			chk(frames, f0 + 1);
			chk(last_len, 5);
			repeat (200) @(posedge pclk);
			u_ufa_host_uart.send(8'h77);
			repeat (200) @(posedge pclk);
			chk(frames, f0 + 1);
			wfr(f0 + 2, 120);
			chk(frames, f0 + 2);
			chk(last_len, 2);
			$display("t_len done");
		end
	endtask
	task t_cmd;
		begin
			apb(1, 8'h00, 32'h11);
			f0 = frames;
			g = ncmd;
			u_ufa_host_uart.send(8'h41);
			repeat (20) @(posedge pclk);
			chk(ncmd, g + 1);
			chk(cmd_got, 8'h41);
			chk(net_join_req, 1'b0);
			// gpio mode: no command, no frame, no join, mode shown in status
			apb(1, 8'h00, 32'h21);
			u_ufa_host_uart.send(8'h42);
			repeat (20) @(posedge pclk);
			chk(ncmd, g + 1);
			chk(net_join_req, 1'b0);
			apb(0, 8'h10, 32'h0);
			chk(rd, 32'h0002_0000);
			repeat (2700) @(posedge pclk);
			chk(frames, f0);
			$display("t_cmd done");
		end
	endtask
	task t_max;
		begin
			apb(1, 8'h00, 32'h1);
			f0 = frames;
			for (i = 0; i < 1000; i = i + 1) u_ufa_host_uart.send(i[7:0]);
			wfr(f0 + 1, 8000);
			chk(frames, f0 + 1);
			chk(last_len, 1000);
			chk(fdat[999], 8'hE7);
			$display("t_max done");
		end
	endtask
	task tally_and_finish;
		begin
			$display("checks %0d mismatches %0d", num_checks, err_total);
			if (err_total == 0 && num_checks > 0) $display("Simulation passed");
			else $display("Simulation failed");
			$finish;
		end
	endtask
	// main sequence
	initial begin
		presetn <= 1'b0;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h0000_0000;
		net_ready <= 1'b0;
		net_link_up <= 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs;
		t_gap(32'h1, 2400);
		t_gap(32'h3, 1900);
		t_len;
		t_cmd;
		t_max;
		tally_and_finish;
	end
	// hang guard
	initial begin
		repeat (70000) @(posedge pclk);
		err_total = err_total + 1;
		tally_and_finish;
	end
endmodule // tb_ufa_frame_aggregator
